// *** logic/smx_core.sv ***
// Execution of register copy, flag, immediate write and side drive for one state machine.
// Assumes a program store that returns instr_i for pc_o in the same cycle,
// and a classic Wishbone master on the register port.
`timescale 1ns/1ps
`include "smx_map.svh"
module smx_core (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Program store
  output logic      [4:0]  pc_o,
  input  wire logic [15:0] instr_i,
  // Status conditions
  input  wire logic        status_a_i,
  input  wire logic        status_b_i,
  // GPIO
  input  wire logic [31:0] gpio_in_i,
  output logic      [31:0] gpio_level_o,
  output logic      [31:0] gpio_dir_o,
  // Shift counts
  output logic      [5:0]  isr_count_o,
  output logic      [5:0]  osr_count_o,
  // Flags and interrupt lines
  output logic      [7:0]  flags_o,
  output logic             irq0_o,
  output logic             irq1_o
);
  smx_pkg::smx_state_t state_reg;
  logic [31:0] run_as_instruction_cfg_reg;
  logic [31:0] pin_cfg_reg;
  logic [4:0]  pc_reg;
  logic [4:0]  dly_cnt_reg;
  logic        run_as_instruction_pend_reg;
  logic [15:0] run_as_instruction_instr_reg;
  logic [2:0]  wait_idx_reg;
  logic [4:0]  wait_dly_reg;
  logic        wait_adv_reg;
  logic [31:0] x_reg;
  logic [31:0] y_reg;
  logic [31:0] isr_reg;
  logic [31:0] osr_reg;
  logic [5:0]  isr_cnt_reg;
  logic [5:0]  osr_cnt_reg;
  logic [31:0] level_reg;
  logic [31:0] dir_reg;
  logic [7:0]  flags_reg;
  logic        ack_reg;
  logic [31:0] rdata_reg;

  logic [15:0] cur;
  logic        active;
  logic        is_mov;
  logic        is_irq;
  logic        is_set;
  logic [2:0]  dst;
  logic [4:0]  ds;
  logic [2:0]  side_cnt;
  logic [2:0]  side_nbits;
  logic [2:0]  set_cnt;
  logic        side_opt;
  logic        side_go;
  logic        side_dir;
  logic [4:0]  side_field;
  logic [4:0]  delay;
  logic        status_bit;
  logic [31:0] pins_in;
  logic [31:0] src_val;
  logic [31:0] rev_val;
  logic [31:0] mov_val;
  logic [2:0]  flag_idx;
  logic [31:0] out_data;
  logic [31:0] out_mask;
  logic [31:0] set_data;
  logic [31:0] set_mask;
  logic [31:0] side_data;
  logic [31:0] side_mask;
  logic [31:0] level_next;
  logic [31:0] dir_next;
  logic [7:0]  flags_next;
  logic        bus_req;
  logic        bus_wr;
  logic [31:0] byte_mask;
  logic [31:0] rd_mux;

  // Instruction decode; a pending run-as-instruction value replaces the fetch
  assign cur    = run_as_instruction_pend_reg ? run_as_instruction_instr_reg : instr_i;
  assign active = run_as_instruction_cfg_reg[`SMX_EC_RUN] && (state_reg == smx_pkg::SMX_ST_RUN);
  assign is_mov = active && (cur[15:13] == `SMX_OP_MOV);
  assign is_irq = active && (cur[15:13] == `SMX_OP_IRQ);
  assign is_set = active && (cur[15:13] == `SMX_OP_SET);
  assign dst    = cur[7:5];
  assign ds     = cur[12:8];

  // Side drive field split
  assign side_cnt   = (pin_cfg_reg[`SMX_PC_SIDE_CNT_LSB +: 3] > `SMX_FIELD_MAX)
                    ? `SMX_FIELD_MAX : pin_cfg_reg[`SMX_PC_SIDE_CNT_LSB +: 3];
  assign set_cnt    = (pin_cfg_reg[`SMX_PC_SET_CNT_LSB +: 3] > `SMX_FIELD_MAX)
                    ? `SMX_FIELD_MAX : pin_cfg_reg[`SMX_PC_SET_CNT_LSB +: 3];
  assign side_field = ds >> (`SMX_FIELD_MAX - side_cnt);
  assign delay      = ds & (5'h1F >> side_cnt);
  assign side_opt   = run_as_instruction_cfg_reg[`SMX_EC_SIDE_OPT] && (side_cnt != 3'h0);
  assign side_go    = active && (side_cnt != 3'h0) && (!side_opt || ds[4]);
  assign side_nbits = side_opt ? side_cnt - 3'h1 : side_cnt;
  assign side_dir   = run_as_instruction_cfg_reg[`SMX_EC_SIDE_DIR];

  assign status_bit = run_as_instruction_cfg_reg[`SMX_EC_STAT_SEL] ? status_b_i : status_a_i;

  smx_pin_map #(.LEFT(1'b0)) u_in_map (
    .data_i  (gpio_in_i),
    .base_i  (pin_cfg_reg[`SMX_PC_IN_BASE_LSB +: 5]),
    .count_i (`SMX_ALL_PINS),
    .data_o  (pins_in),
    .mask_o  ()
  );

  // Copy source select and operation
  always_comb begin
    case (cur[2:0])
      smx_pkg::SMX_SRC_PINS:   src_val = pins_in;
      smx_pkg::SMX_SRC_X:      src_val = x_reg;
      smx_pkg::SMX_SRC_Y:      src_val = y_reg;
      smx_pkg::SMX_SRC_STATUS: src_val = {32{status_bit}};
      smx_pkg::SMX_SRC_ISR:    src_val = isr_reg;
      smx_pkg::SMX_SRC_OSR:    src_val = osr_reg;
      default:                 src_val = `SMX_WORD_ZERO;
    endcase
  end

  always_comb begin
    for (int i = 0; i < 32; i++) begin
      rev_val[i] = src_val[31 - i];
    end
  end

  always_comb begin
    case (cur[4:3])
      smx_pkg::SMX_MOP_INV: mov_val = ~src_val;
      smx_pkg::SMX_MOP_REV: mov_val = rev_val;
      default:              mov_val = src_val;
    endcase
  end

  smx_flag_sel u_flag_sel (
    .index_i   (cur[4:0]),
    .machine_i (run_as_instruction_cfg_reg[`SMX_EC_MID_LSB +: 2]),
    .flag_o    (flag_idx)
  );

  // Output mapping for copies, separate mapping for immediate writes
  smx_pin_map #(.LEFT(1'b1)) u_out_map (
    .data_i  (mov_val),
    .base_i  (pin_cfg_reg[`SMX_PC_OUT_BASE_LSB +: 5]),
    .count_i (pin_cfg_reg[`SMX_PC_OUT_CNT_LSB +: 6]),
    .data_o  (out_data),
    .mask_o  (out_mask)
  );

  smx_pin_map #(.LEFT(1'b1)) u_set_map (
    .data_i  ({27'h000_0000, cur[4:0]}),
    .base_i  (pin_cfg_reg[`SMX_PC_SET_BASE_LSB +: 5]),
    .count_i ({3'h0, set_cnt}),
    .data_o  (set_data),
    .mask_o  (set_mask)
  );

  smx_pin_map #(.LEFT(1'b1)) u_side_map (
    .data_i  ({27'h000_0000, side_field}),
    .base_i  (pin_cfg_reg[`SMX_PC_SIDE_BASE_LSB +: 5]),
    .count_i ({3'h0, side_nbits}),
    .data_o  (side_data),
    .mask_o  (side_mask)
  );

  // Sequencing: program counter, delay, flag wait, run-as-instruction
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg      <= smx_pkg::SMX_ST_RUN;
      pc_reg         <= 5'h00;
      dly_cnt_reg    <= 5'h00;
      run_as_instruction_pend_reg  <= 1'b0;
      run_as_instruction_instr_reg <= 16'h0000;
      wait_idx_reg   <= 3'h0;
      wait_dly_reg   <= 5'h00;
      wait_adv_reg   <= 1'b0;
    end else begin
      case (state_reg)
        smx_pkg::SMX_ST_RUN: begin
          if (active) begin
            run_as_instruction_pend_reg <= 1'b0;
            if (is_mov && (dst == smx_pkg::SMX_DST_RUN_AS_INSTRUCTION)) begin
              // Delay on this copy is dropped
              run_as_instruction_instr_reg <= mov_val[15:0];
              run_as_instruction_pend_reg  <= 1'b1;
              if (!run_as_instruction_pend_reg) begin
                pc_reg <= pc_reg + 5'h01;
              end
            end else if (is_mov && (dst == smx_pkg::SMX_DST_PC)) begin
              pc_reg <= mov_val[4:0];
              if (delay != 5'h00) begin
                state_reg   <= smx_pkg::SMX_ST_DELAY;
                dly_cnt_reg <= delay;
              end
            end else if (is_irq && !cur[6] && cur[5]) begin
              state_reg    <= smx_pkg::SMX_ST_FLAG_WAIT;
              wait_idx_reg <= flag_idx;
              wait_dly_reg <= delay;
              wait_adv_reg <= !run_as_instruction_pend_reg;
            end else begin
              if (!run_as_instruction_pend_reg) begin
                pc_reg <= pc_reg + 5'h01;
              end
              if (delay != 5'h00) begin
                state_reg   <= smx_pkg::SMX_ST_DELAY;
                dly_cnt_reg <= delay;
              end
            end
          end
        end
        smx_pkg::SMX_ST_DELAY: begin
          dly_cnt_reg <= dly_cnt_reg - 5'h01;
          if (dly_cnt_reg == 5'h01) begin
            state_reg <= smx_pkg::SMX_ST_RUN;
          end
        end
        smx_pkg::SMX_ST_FLAG_WAIT: begin
          if (!flags_reg[wait_idx_reg]) begin
            if (wait_adv_reg) begin
              pc_reg <= pc_reg + 5'h01;
            end
            if (wait_dly_reg != 5'h00) begin
              state_reg   <= smx_pkg::SMX_ST_DELAY;
              dly_cnt_reg <= wait_dly_reg;
            end else begin
              state_reg <= smx_pkg::SMX_ST_RUN;
            end
          end
        end
        default: begin
          state_reg <= smx_pkg::SMX_ST_RUN;
        end
      endcase
    end
  end

  // Scratch registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      x_reg <= `SMX_WORD_ZERO;
      y_reg <= `SMX_WORD_ZERO;
    end else begin
      if (is_mov && (dst == smx_pkg::SMX_DST_X)) begin
        x_reg <= mov_val;
      end else if (is_set && (dst == smx_pkg::SMX_SET_X)) begin
        x_reg <= {27'h000_0000, cur[4:0]};
      end
      if (is_mov && (dst == smx_pkg::SMX_DST_Y)) begin
        y_reg <= mov_val;
      end else if (is_set && (dst == smx_pkg::SMX_SET_Y)) begin
        y_reg <= {27'h000_0000, cur[4:0]};
      end
    end
  end

  // Shift registers and their counts
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      isr_reg     <= `SMX_WORD_ZERO;
      osr_reg     <= `SMX_WORD_ZERO;
      isr_cnt_reg <= 6'h00;
      osr_cnt_reg <= `SMX_OSR_COUNT_RST;
    end else begin
      if (is_mov && (dst == smx_pkg::SMX_DST_ISR)) begin
        isr_reg     <= mov_val;
        isr_cnt_reg <= 6'h00;
      end
      if (is_mov && (dst == smx_pkg::SMX_DST_OSR)) begin
        osr_reg     <= mov_val;
        osr_cnt_reg <= 6'h00;
      end
    end
  end

  // Pin levels and directions; side drive is applied last so it wins
  always_comb begin
    level_next = level_reg;
    dir_next   = dir_reg;
    if (is_mov && (dst == smx_pkg::SMX_DST_PINS)) begin
      level_next = (level_next & ~out_mask) | out_data;
    end
    if (is_set && (dst == smx_pkg::SMX_SET_PINS)) begin
      level_next = (level_next & ~set_mask) | set_data;
    end
    if (is_set && (dst == smx_pkg::SMX_SET_PINDIRS)) begin
      dir_next = (dir_next & ~set_mask) | set_data;
    end
    if (side_go && side_dir) begin
      dir_next = (dir_next & ~side_mask) | side_data;
    end else if (side_go) begin
      level_next = (level_next & ~side_mask) | side_data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level_reg <= `SMX_WORD_ZERO;
      dir_reg   <= `SMX_WORD_ZERO;
    end else begin
      level_reg <= level_next;
      dir_reg   <= dir_next;
    end
  end

  // Flags: software write-one clears, an instruction set in the same cycle wins
  always_comb begin
    flags_next = flags_reg;
    if (bus_wr && ({wb_adr_i[7:2], 2'b00} == `SMX_ADDR_FLAGS)) begin
      flags_next = flags_next & ~(wb_dat_i[7:0] & byte_mask[7:0]);
    end
    if (is_irq) begin
      flags_next[flag_idx] = !cur[6];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_reg <= 8'h00;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // Wishbone slave: ack one cycle after the request, writes commit at ack
  assign bus_req   = wb_cyc_i && wb_stb_i;
  assign bus_wr    = bus_req && wb_we_i && ack_reg;
  assign byte_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  always_comb begin
    case ({wb_adr_i[7:2], 2'b00})
      `SMX_ADDR_RUN_AS_INSTRUCTION_CFG:  rd_mux = run_as_instruction_cfg_reg;
      `SMX_ADDR_PIN_CFG:   rd_mux = pin_cfg_reg;
      `SMX_ADDR_FLAGS:     rd_mux = {24'h00_0000, flags_reg};
      `SMX_ADDR_SCRATCH_X: rd_mux = x_reg;
      `SMX_ADDR_SCRATCH_Y: rd_mux = y_reg;
      `SMX_ADDR_ISR:       rd_mux = isr_reg;
      `SMX_ADDR_OSR:       rd_mux = osr_reg;
      `SMX_ADDR_STATUS:    rd_mux = {12'h000, osr_cnt_reg, isr_cnt_reg, run_as_instruction_pend_reg,
                                     state_reg, pc_reg};
      default:             rd_mux = `SMX_WORD_ZERO;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg   <= 1'b0;
      rdata_reg <= `SMX_WORD_ZERO;
    end else begin
      ack_reg <= bus_req && !ack_reg;
      if (bus_req && !ack_reg) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_as_instruction_cfg_reg <= `SMX_RUN_AS_INSTRUCTION_CFG_RST;
      pin_cfg_reg  <= `SMX_PIN_CFG_RST;
    end else if (bus_wr) begin
      if ({wb_adr_i[7:2], 2'b00} == `SMX_ADDR_RUN_AS_INSTRUCTION_CFG) begin
        run_as_instruction_cfg_reg <= (run_as_instruction_cfg_reg & ~byte_mask) | (wb_dat_i & byte_mask);
      end
      if ({wb_adr_i[7:2], 2'b00} == `SMX_ADDR_PIN_CFG) begin
        pin_cfg_reg <= (pin_cfg_reg & ~byte_mask) | (wb_dat_i & byte_mask);
      end
    end
  end

  // Outputs
  assign wb_dat_o     = rdata_reg;
  assign wb_ack_o     = ack_reg;
  assign pc_o         = pc_reg;
  assign gpio_level_o = level_reg;
  assign gpio_dir_o   = dir_reg;
  assign isr_count_o  = isr_cnt_reg;
  assign osr_count_o  = osr_cnt_reg;
  assign flags_o      = flags_reg;
  assign irq0_o       = |(flags_reg[3:0] & run_as_instruction_cfg_reg[`SMX_EC_L0EN_LSB +: 4]);
  assign irq1_o       = |(flags_reg[3:0] & run_as_instruction_cfg_reg[`SMX_EC_L1EN_LSB +: 4]);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_isr_count_clear: assert property (is_mov && dst == 3'b110
    |=> isr_cnt_reg == 6'h00 && isr_reg == $past(mov_val)) else $error("input shift copy");
  a_osr_count_full: assert property (is_mov && dst == 3'b111
    |=> osr_cnt_reg == 6'h00) else $error("output shift count not cleared");
  a_invert_copy: assert property (is_mov && dst == 3'b001 && cur[4:3] == 2'b01
    |=> x_reg == ~$past(src_val)) else $error("inverted copy wrong");
  a_reverse_copy: assert property (is_mov && dst == 3'b010 && cur[4:3] == 2'b10
    |=> y_reg[0] == $past(src_val[31]) && y_reg[31] == $past(src_val[0]))
    else $error("reversed copy wrong");
  a_pc_jump: assert property (is_mov && dst == 3'b101
    |=> pc_reg == $past(mov_val[4:0])) else $error("jump target wrong");
  a_run_as_instruction_next: assert property (is_mov && dst == 3'b100
    |=> state_reg == smx_pkg::SMX_ST_RUN && run_as_instruction_pend_reg
        && run_as_instruction_instr_reg == $past(mov_val[15:0])) else $error("run value not next");
  a_flag_raise: assert property (is_irq && !cur[6]
    |=> flags_reg[$past(flag_idx)]) else $error("flag not raised");
  a_flag_clear: assert property (is_irq && cur[6]
    |=> !flags_reg[$past(flag_idx)] && state_reg != smx_pkg::SMX_ST_FLAG_WAIT)
    else $error("flag clear wrong");
  a_wait_holds: assert property (state_reg == smx_pkg::SMX_ST_FLAG_WAIT
    && flags_reg[wait_idx_reg] |=> state_reg == smx_pkg::SMX_ST_FLAG_WAIT)
    else $error("wait left early");
  a_delay_after_wait: assert property (state_reg == smx_pkg::SMX_ST_FLAG_WAIT
    && !flags_reg[wait_idx_reg] && wait_dly_reg != 5'h00
    |=> state_reg == smx_pkg::SMX_ST_DELAY && dly_cnt_reg == $past(wait_dly_reg))
    else $error("delay after wait wrong");
  a_side_wins: assert property (side_go && !side_dir
    |=> (level_reg & $past(side_mask)) == $past(side_data)) else $error("side drive lost");
  a_imm_scratch: assert property (is_set && dst == 3'b001
    |=> x_reg == {27'h000_0000, $past(cur[4:0])}) else $error("immediate X wrong");
  a_delay_leave: assert property (state_reg == smx_pkg::SMX_ST_DELAY && dly_cnt_reg == 5'h01
    |=> state_reg == smx_pkg::SMX_ST_RUN) else $error("delay end wrong");

  c_run_as_instruction_copy: cover property (is_mov && dst == 3'b100 ##1 run_as_instruction_pend_reg);
  c_flag_wait: cover property (state_reg == smx_pkg::SMX_ST_FLAG_WAIT ##1
    state_reg == smx_pkg::SMX_ST_DELAY);
  c_side_dir: cover property (side_go && side_dir);
  c_pc_jump: cover property (is_mov && dst == 3'b101);
endmodule : smx_core

// *** logic/smx_flag_sel.sv ***
// Flag index resolution with optional machine-relative offset.
// Assumes machine numbers 0 to 3.
`timescale 1ns/1ps
module smx_flag_sel (
  // Index field and machine number
  input  wire logic [4:0] index_i,
  input  wire logic [1:0] machine_i,
  // Resolved flag
  output logic      [2:0] flag_o
);
  logic [1:0] rel_low;

  // Modulo-4 sum on the two low bits only; bit 2 passes unchanged
  assign rel_low = index_i[1:0] + machine_i;
  assign flag_o  = index_i[4] ? {index_i[2], rel_low} : index_i[2:0];
endmodule : smx_flag_sel

// *** logic/smx_pin_map.sv ***
// Rotating pin mapper: places count low bits at a base pin, wrapping after pin 31.
// Assumes a 32-pin bank; combinational only.
`timescale 1ns/1ps
`include "smx_map.svh"
module smx_pin_map #(
  parameter bit LEFT = 1'b1
) (
  // Data and mapping
  input  wire logic [31:0] data_i,
  input  wire logic [4:0]  base_i,
  input  wire logic [5:0]  count_i,
  // Mapped result
  output logic      [31:0] data_o,
  output logic      [31:0] mask_o
);
  logic [31:0] low_mask;
  logic [63:0] dbl_data;
  logic [63:0] dbl_mask;

  assign low_mask = count_i[5] ? ~`SMX_WORD_ZERO
                  : ((32'h0000_0001 << count_i[4:0]) - 32'h0000_0001);

  always_comb begin
    if (LEFT) begin
      dbl_data = {data_i & low_mask, data_i & low_mask} << base_i;
      dbl_mask = {low_mask, low_mask} << base_i;
      data_o   = dbl_data[63:32];
      mask_o   = dbl_mask[63:32];
    end else begin
      // Input direction: bit 0 comes from the base pin
      dbl_data = {data_i, data_i} >> base_i;
      dbl_mask = {low_mask, low_mask};
      data_o   = dbl_data[31:0] & low_mask;
      mask_o   = dbl_mask[31:0];
    end
  end
endmodule : smx_pin_map

// *** pkg/smx_map.svh ***
// Offsets, field positions, reset values and opcode codes of the state machine block.
// Assumes inclusion by bare name from any file that needs them.
`ifndef SMX_MAP_SVH
`define SMX_MAP_SVH

// Register byte offsets
`define SMX_ADDR_RUN_AS_INSTRUCTION_CFG   8'h00
`define SMX_ADDR_PIN_CFG    8'h04
`define SMX_ADDR_FLAGS      8'h08
`define SMX_ADDR_SCRATCH_X  8'h0C
`define SMX_ADDR_SCRATCH_Y  8'h10
`define SMX_ADDR_ISR        8'h14
`define SMX_ADDR_OSR        8'h18
`define SMX_ADDR_STATUS     8'h1C

// Execution config fields
`define SMX_EC_RUN          0
`define SMX_EC_MID_LSB      1
`define SMX_EC_SIDE_OPT     3
`define SMX_EC_SIDE_DIR     4
`define SMX_EC_STAT_SEL     5
`define SMX_EC_L0EN_LSB     8
`define SMX_EC_L1EN_LSB     12

// Pin config fields
`define SMX_PC_IN_BASE_LSB   0
`define SMX_PC_OUT_BASE_LSB  5
`define SMX_PC_SET_BASE_LSB  10
`define SMX_PC_SIDE_BASE_LSB 15
`define SMX_PC_OUT_CNT_LSB   20
`define SMX_PC_SET_CNT_LSB   26
`define SMX_PC_SIDE_CNT_LSB  29

// Reset values
`define SMX_RUN_AS_INSTRUCTION_CFG_RST    32'h0000_0000
`define SMX_PIN_CFG_RST     32'h0000_0000
`define SMX_OSR_COUNT_RST   6'h20
`define SMX_WORD_ZERO       32'h0000_0000

// Limits and codes
`define SMX_FIELD_MAX       3'h5
`define SMX_ALL_PINS        6'h20
`define SMX_OP_MOV          3'h5
`define SMX_OP_IRQ          3'h6
`define SMX_OP_SET          3'h7

`endif

// *** pkg/smx_pkg.sv ***
// Types of the state machine block: control states and operand codes.
// Assumes nothing of its surroundings.
package smx_pkg;

  typedef enum logic [1:0] {
    SMX_ST_RUN       = 2'b00,
    SMX_ST_DELAY     = 2'b01,
    SMX_ST_FLAG_WAIT = 2'b10
  } smx_state_t;

  typedef enum logic [2:0] {
    SMX_DST_PINS  = 3'b000,
    SMX_DST_X     = 3'b001,
    SMX_DST_Y     = 3'b010,
    SMX_DST_RSVD  = 3'b011,
    SMX_DST_RUN_AS_INSTRUCTION  = 3'b100,
    SMX_DST_PC    = 3'b101,
    SMX_DST_ISR   = 3'b110,
    SMX_DST_OSR   = 3'b111
  } smx_dst_t;

  typedef enum logic [2:0] {
    SMX_SRC_PINS   = 3'b000,
    SMX_SRC_X      = 3'b001,
    SMX_SRC_Y      = 3'b010,
    SMX_SRC_NULL   = 3'b011,
    SMX_SRC_RSVD   = 3'b100,
    SMX_SRC_STATUS = 3'b101,
    SMX_SRC_ISR    = 3'b110,
    SMX_SRC_OSR    = 3'b111
  } smx_src_t;

  typedef enum logic [1:0] {
    SMX_MOP_NONE = 2'b00,
    SMX_MOP_INV  = 2'b01,
    SMX_MOP_REV  = 2'b10,
    SMX_MOP_RSVD = 2'b11
  } smx_mop_t;

  typedef enum logic [2:0] {
    SMX_SET_PINS    = 3'b000,
    SMX_SET_X       = 3'b001,
    SMX_SET_Y       = 3'b010,
    SMX_SET_PINDIRS = 3'b100
  } smx_set_dst_t;

endpackage : smx_pkg

// *** tb/smx_core_tb.sv ***
// Self-checking bench for the state machine core.
// Assumes the program held in smx_pstore and classic Wishbone register access.
`timescale 1ns/1ps
`include "smx_map.svh"
module smx_core_tb;
  logic        clk_i;
  logic        rst_i;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat;
  logic [31:0] rdat;
  logic        ack;
  logic [4:0]  pc;
  logic [15:0] instr;
  logic [31:0] lvl;
  logic [31:0] dir;
  logic [31:0] gin;
  logic [5:0]  icnt;
  logic [5:0]  ocnt;
  logic [7:0]  flags;
  logic        irq0;
  logic        irq1;
  int          fails;
  int          checked;
  int          cycles;

  smx_core i_smx_core (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .pc_o(pc), .instr_i(instr), .status_a_i(1'b0), .status_b_i(1'b1),
    .gpio_in_i(gin), .gpio_level_o(lvl), .gpio_dir_o(dir),
    .isr_count_o(icnt), .osr_count_o(ocnt), .flags_o(flags), .irq0_o(irq0), .irq1_o(irq1)
  );
  smx_pstore i_smx_pstore (.pc_i(pc), .instr_o(instr));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic give_verdict();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One classic cycle; read data is taken at the ack edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0000_0000, q);
    chk(q, exp);
  endtask : rd

  initial begin
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'hF;
    dat = 32'h0000_0000;
    gin = 32'hA5AE_29F5;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({26'h0, ocnt}, 32'h0000_0020);
    // Side drive: one bit at pin 7; machine 2, flag 3 routed to line 0
    wr(`SMX_ADDR_PIN_CFG, 32'h2003_8000);
    wr(`SMX_ADDR_RUN_AS_INSTRUCTION_CFG, 32'h0000_0805);
    repeat (15) @(posedge clk_i);
    wr(`SMX_ADDR_SCRATCH_X, 32'h0000_0000);
    rd(`SMX_ADDR_SCRATCH_X, 32'hFFFF_FFF5);
    rd(`SMX_ADDR_SCRATCH_Y, 32'hAFFF_FFFF);
    rd(`SMX_ADDR_ISR, 32'hFFFF_FFF5);
    rd(`SMX_ADDR_OSR, 32'h0000_0000);
    rd(8'h20, 32'h0000_0000);
    rd(`SMX_ADDR_STATUS, 32'h0000_0048);
    chk({20'h0, icnt, ocnt}, 32'h0000_0000);
    chk({24'h0, flags}, 32'h0000_0068);
    chk({30'h0, irq0, irq1}, 32'h0000_0002);
    chk({31'h0, lvl[7]}, 32'h0000_0001);
    wr(`SMX_ADDR_FLAGS, 32'h0000_0008);
    chk({23'h0, irq0, flags}, 32'h0000_0060);
    // Second phase: optional side drive on directions, wrapping past pin 31
    wr(`SMX_ADDR_PIN_CFG, 32'h748F_C104);
    wr(`SMX_ADDR_RUN_AS_INSTRUCTION_CFG, 32'h0000_FF3D);
    wr(`SMX_ADDR_FLAGS, 32'h0000_0040);
    repeat (20) @(posedge clk_i);
    rd(`SMX_ADDR_SCRATCH_X, 32'h5A5A_E29F);
    rd(`SMX_ADDR_SCRATCH_Y, 32'hFFFF_FFFF);
    rd(`SMX_ADDR_STATUS, 32'h0000_005F);
    chk(lvl, 32'h0015_FF80);
    chk(dir, 32'h801F_0000);
    chk({22'h0, irq0, irq1, flags}, 32'h0000_0080);
    give_verdict();
  end
endmodule : smx_core_tb

// *** tb/smx_pstore.sv ***
// Program store model for the state machine core.
// Assumes a 32-word store read combinationally at the program counter.
`timescale 1ns/1ps
module smx_pstore (
  // Program counter
  input  wire logic [4:0]  pc_i,
  // Instruction
  output logic      [15:0] instr_o
);
  // Unused words are no-ops whose single side bit is high
  always_comb begin
    case (pc_i)
      5'h00:   instr_o = 16'hF035;
      5'h01:   instr_o = 16'hE04A;
      5'h02:   instr_o = 16'hA02A;
      5'h03:   instr_o = 16'hA051;
      5'h04:   instr_o = 16'hA0E3;
      5'h05:   instr_o = 16'hA0C1;
      5'h06:   instr_o = 16'hC005;
      5'h07:   instr_o = 16'hC011;
      // Halt on flag 6; the second phase follows once software lowers it
      5'h08:   instr_o = 16'hD326;
      5'h09:   instr_o = 16'hA020;
      5'h0A:   instr_o = 16'hA045;
      5'h0B:   instr_o = 16'hBC0B;
      5'h0C:   instr_o = 16'hE015;
      5'h0D:   instr_o = 16'hA080;
      5'h0E:   instr_o = 16'hC077;
      5'h0F:   instr_o = 16'hB4A2;
      5'h1F:   instr_o = 16'hC027;
      default: instr_o = 16'h1000;
    endcase
  end
endmodule : smx_pstore
